// File: design/cag_core.sv
// Purpose : Next program counter and operand effective address generation
// Assumes : Decoder supplies mode, length and instruction bytes each step
// Notes   : Register file read in two cycles is external; pair values are inputs
//
// Summary of operation
// RULE_01 - Sequential fetch adds instruction length to program counter.
// RULE_02 - Relative branch loads next-instruction address plus displacement byte.
// RULE_03 - Displacement is signed, bit 7 sign, extended to 16 bits.
// RULE_04 - Relative form used for short branch and all conditional branches.
// RULE_05 - Absolute call and branch copy the 16-bit target.
// RULE_06 - Fixed-area call reaches only 0800H to 0FFFH from 11 bits.
// RULE_07 - Table call picks entry at 40H-7FH by opcode bits 1-5.
// RULE_08 - Register branch loads program counter from accumulator pair.
// RULE_09 - Multiply reads accumulator byte, writes product to accumulator pair.
// RULE_10 - Word divide reads and writes the accumulator pair.
// RULE_11 - Decimal adjust and digit rotate use the accumulator byte.
// RULE_12 - Registers taken from bank chosen by two select bits, 3-bit code.
// RULE_13 - Byte codes X,A,C,B,E,D,L,H; pair codes accumulator,BC,DE,base.
// RULE_14 - Direct mode uses 16-bit immediate unchanged as address.
// RULE_15 - Short direct addresses lie in FE20H to FF1FH.
// RULE_16 - Short direct bit 8 clear for 20H-FFH, set for 00H-1FH.
// RULE_17 - Software gives only even addresses for 16-bit short direct.
// RULE_18 - Special-register mode reaches FF00H-FFCFH and FFE0H-FFFFH.
// RULE_19 - Software names only even 16-bit-capable special registers.
// RULE_20 - Register indirect uses selected pair of active bank.
// RULE_21 - Based adds zero-extended offset to base pair, carry dropped.
// RULE_22 - Special-register address is FFH high byte, instruction byte low.
`timescale 1ns/1ps
`default_nettype none
module cag_core
   import cag_pkg::*;
#(
   parameter int LEN_W = 3
)(
   input  wire logic                  clk_in,
   input  wire logic                  srst_in,
   input  wire logic                  step_in,
   input  wire cag_pkg::cag_pc_mode_e pc_mode_in,
   input  wire logic                  cond_taken_in,
   input  wire logic [LEN_W-1:0]      instr_len_in,
   input  wire logic [7:0]            opcode_in,
   input  wire logic [7:0]            imm_byte_in,
   input  wire logic [15:0]           imm_word_in,
   input  wire logic [15:0]           table_entry_in,
   input  wire cag_pkg::cag_op_mode_e op_mode_in,
   input  wire cag_pkg::cag_imp_op_e  imp_op_in,
   input  wire logic [2:0]            byte_register_code_in,
   input  wire logic [1:0]            pair_register_code_in,
   input  wire logic                  bank_select_low_in,
   input  wire logic                  bank_select_high_in,
   input  wire logic [15:0]           accumulator_pair_in,
   input  wire logic [15:0]           sel_pair_in,
   input  wire logic [15:0]           base_pointer_pair_in,
   output var  logic [15:0]           pc_out,
   output var  logic [15:0]           table_addr_out,
   output var  logic [15:0]           op_addr_out,
   output var  logic                  op_is_mem_out,
   output var  logic [4:0]            src_reg_index_out,
   output var  logic [4:0]            dst_reg_index_out,
   output var  logic                  src_is_pair_out,
   output var  logic                  dst_is_pair_out
);
   import cag_pkg::*;

   // -----------------------------------------------------------------
   // Address functions
   // -----------------------------------------------------------------
   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v}; // [RULE_03]
   endfunction

   // Codes below 20H fold up onto FF00H to FF1FH
   function automatic logic [15:0] short_addr(input logic [7:0] v);
      logic bit8;
      bit8 = (v < SADDR_WRAP_LIM); // [RULE_16]
      short_addr = {SADDR_HI, bit8, v}; // [RULE_15]
   endfunction

   // -----------------------------------------------------------------
   // Register index mapping
   // -----------------------------------------------------------------
   logic [4:0] byte_idx;
   logic [4:0] pair_idx;
   logic [4:0] acc_byte_idx;
   logic [4:0] acc_pair_idx;

   // Pair slots are even, high byte one slot up
   cag_reg_map u_map (
      .bank_select_low_in    (bank_select_low_in),
      .bank_select_high_in   (bank_select_high_in),
      .byte_register_code_in (byte_register_code_in),
      .pair_register_code_in (pair_register_code_in),
      .byte_index_out        (byte_idx),
      .pair_index_out        (pair_idx)
   );

   // Accumulator codes fixed for implied operands
   cag_reg_map u_acc_map (
      .bank_select_low_in    (bank_select_low_in),
      .bank_select_high_in   (bank_select_high_in),
      .byte_register_code_in (REG_A),
      .pair_register_code_in (PAIR_ACC),
      .byte_index_out        (acc_byte_idx),
      .pair_index_out        (acc_pair_idx)
   );

   // -----------------------------------------------------------------
   // Table call entry address
   // -----------------------------------------------------------------
   cag_pc_table u_table (
      .clk_in         (clk_in),
      .srst_in        (srst_in),
      .opcode_in      (opcode_in),
      .entry_addr_out (table_addr_out)
   );

   // -----------------------------------------------------------------
   // Next program counter
   // -----------------------------------------------------------------
   logic [15:0] seq_pc;
   logic [15:0] pc_nxt;

   // Start of the following instruction, base of relative targets
   always_comb begin
      seq_pc = pc_out + 16'(instr_len_in); // [RULE_01]
   end

   always_comb begin
      pc_nxt = pc_out;
      unique case (pc_mode_in)
         CAG_PC_SEQ: begin
            pc_nxt = seq_pc; // [RULE_01]
         end

         CAG_PC_REL: begin
            // Conditional branches fall through when not taken
            if (cond_taken_in) begin
               pc_nxt = seq_pc + sext8(imm_byte_in); // [RULE_02] [RULE_04]
            end else begin
               pc_nxt = seq_pc;
            end
         end

         CAG_PC_ABS: begin
            pc_nxt = imm_word_in; // [RULE_05]
         end

         CAG_PC_FIXED: begin
            pc_nxt = {FIXED_CALL_HI, imm_word_in[10:0]}; // [RULE_06]
         end

         CAG_PC_TABLE: begin
            pc_nxt = table_entry_in; // [RULE_07]
         end

         CAG_PC_ACC: begin
            pc_nxt = accumulator_pair_in; // [RULE_08]
         end

         CAG_PC_HOLD: begin
            pc_nxt = pc_out;
         end

         // Spare code of the mode field
         default: begin
            pc_nxt = pc_out;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Program counter register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pc_out <= PC_RESET;
      end else if (step_in) begin
         pc_out <= pc_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Operand effective address
   // -----------------------------------------------------------------
   logic [15:0] op_addr_nxt;
   logic        op_mem_nxt;

   always_comb begin
      op_addr_nxt = 16'h0000;
      op_mem_nxt  = 1'b0;
      unique case (op_mode_in)
         CAG_OP_DIRECT: begin
            op_addr_nxt = imm_word_in; // [RULE_14]
            op_mem_nxt  = 1'b1;
         end

         CAG_OP_SHORT: begin
            op_addr_nxt = short_addr(imm_byte_in); // [RULE_15] [RULE_16]
            op_mem_nxt  = 1'b1;
         end

         CAG_OP_SFR: begin
            op_addr_nxt = {SFR_HI, imm_byte_in}; // [RULE_18] [RULE_22]
            op_mem_nxt  = 1'b1;
         end

         CAG_OP_INDIRECT: begin
            op_addr_nxt = sel_pair_in; // [RULE_20]
            op_mem_nxt  = 1'b1;
         end

         // Sum keeps 16 bits, carry out of bit 15 is lost
         CAG_OP_BASED: begin
            op_addr_nxt = base_pointer_pair_in + {8'h00, imm_byte_in}; // [RULE_21]
            op_mem_nxt  = 1'b1;
         end

         // Implied and register modes reach no memory
         default: begin
            op_addr_nxt = 16'h0000;
            op_mem_nxt  = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Operand address registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         op_addr_out <= 16'h0000;
      end else if (step_in) begin
         op_addr_out <= op_addr_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         op_is_mem_out <= 1'b0;
      end else if (step_in) begin
         op_is_mem_out <= op_mem_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Register operand selection
   // -----------------------------------------------------------------
   logic [4:0] src_nxt;
   logic [4:0] dst_nxt;
   logic       src_pair_nxt;
   logic       dst_pair_nxt;

   // Memory modes leave both indexes at slot 0
   always_comb begin
      src_nxt      = 5'h00;
      dst_nxt      = 5'h00;
      src_pair_nxt = 1'b0;
      dst_pair_nxt = 1'b0;
      unique case (op_mode_in)
         CAG_OP_REG_BYTE: begin
            src_nxt = byte_idx; // [RULE_12] [RULE_13]
            dst_nxt = byte_idx;
         end

         CAG_OP_REG_PAIR: begin
            src_nxt      = pair_idx; // [RULE_13]
            dst_nxt      = pair_idx;
            src_pair_nxt = 1'b1;
            dst_pair_nxt = 1'b1;
         end

         CAG_OP_IMPLIED_BYTE, CAG_OP_IMPLIED_PAIR: begin
            unique case (imp_op_in)
               CAG_IMP_MULTIPLY: begin
                  // Other factor is not selected here; the register field is unused for multiply
                  src_nxt      = acc_byte_idx; // [RULE_09]
                  dst_nxt      = acc_pair_idx;
                  dst_pair_nxt = 1'b1;
               end

               CAG_IMP_DIVIDE: begin
                  src_nxt      = acc_pair_idx; // [RULE_10]
                  dst_nxt      = acc_pair_idx;
                  src_pair_nxt = 1'b1;
                  dst_pair_nxt = 1'b1;
               end

               CAG_IMP_ADJ_ADD, CAG_IMP_ADJ_SUB,
               CAG_IMP_ROT_RIGHT, CAG_IMP_ROT_LEFT: begin
                  src_nxt = acc_byte_idx; // [RULE_11]
                  dst_nxt = acc_byte_idx;
               end

               default: begin
                  src_nxt = acc_byte_idx;
                  dst_nxt = acc_byte_idx;
               end
            endcase
         end

         default: begin
            src_nxt = 5'h00;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Register operand outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         src_reg_index_out <= 5'h00;
      end else if (step_in) begin
         src_reg_index_out <= src_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         dst_reg_index_out <= 5'h00;
      end else if (step_in) begin
         dst_reg_index_out <= dst_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         src_is_pair_out <= 1'b0;
      end else if (step_in) begin
         src_is_pair_out <= src_pair_nxt;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         dst_is_pair_out <= 1'b0;
      end else if (step_in) begin
         dst_is_pair_out <= dst_pair_nxt;
      end
   end
endmodule
`default_nettype wire

// File: design/cag_pc_table.sv
// Purpose : Table-call entry address built from the opcode index bits
// Assumes : Index is opcode immediate bits 1 to 5
// Notes   : Outputs registered
`timescale 1ns/1ps
`default_nettype none
module cag_pc_table
   import cag_pkg::*;
(
   input  wire logic                  clk_in,
   input  wire logic                  srst_in,
   input  wire logic [7:0]            opcode_in,
   output var  logic [15:0]           entry_addr_out
);
   import cag_pkg::*;

   // -----------------------------------------------------------------
   // Entry address 0040H + 2*index
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         entry_addr_out <= 16'h0000;
      end else begin
         entry_addr_out <= {TABLE_BASE_HI, opcode_in[5:1], 1'b0}; // [RULE_07]
      end
   end
endmodule
`default_nettype wire

// File: design/cag_pkg.sv
// Purpose : Shared constants and types for the CPU address generation block
// Assumes : 16-bit address space, 8-bit data, four register banks
// Notes   : Area offsets, register codes and the program counter reset value live here
package cag_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Program counter after reset
   localparam logic [15:0] PC_RESET = 16'h0000;

   // Fixed-area call base
   localparam logic [4:0] FIXED_CALL_HI = 5'h01;

   // Table call area
   localparam logic [9:0] TABLE_BASE_HI = 10'h001;

   // Short direct window
   localparam logic [6:0] SADDR_HI       = 7'h7F;
   localparam logic [7:0] SADDR_WRAP_LIM = 8'h20;

   // Special-register upper byte
   localparam logic [7:0] SFR_HI = 8'hFF;

   // Byte register codes
   localparam logic [2:0] REG_X = 3'h0;
   localparam logic [2:0] REG_A = 3'h1;
   localparam logic [2:0] REG_C = 3'h2;
   localparam logic [2:0] REG_B = 3'h3;
   localparam logic [2:0] REG_E = 3'h4;
   localparam logic [2:0] REG_D = 3'h5;
   localparam logic [2:0] REG_L = 3'h6;
   localparam logic [2:0] REG_H = 3'h7;

   // Pair register codes
   localparam logic [1:0] PAIR_ACC  = 2'h0;
   localparam logic [1:0] PAIR_BC   = 2'h1;
   localparam logic [1:0] PAIR_DE   = 2'h2;
   localparam logic [1:0] PAIR_BASE = 2'h3;

   // Program-counter source
   typedef enum logic [2:0] {
      CAG_PC_SEQ,
      CAG_PC_REL,
      CAG_PC_ABS,
      CAG_PC_FIXED,
      CAG_PC_TABLE,
      CAG_PC_ACC,
      CAG_PC_HOLD
   } cag_pc_mode_e;

   // Operand address mode
   typedef enum logic [3:0] {
      CAG_OP_NONE,
      CAG_OP_IMPLIED_BYTE,
      CAG_OP_IMPLIED_PAIR,
      CAG_OP_REG_BYTE,
      CAG_OP_REG_PAIR,
      CAG_OP_DIRECT,
      CAG_OP_SHORT,
      CAG_OP_SFR,
      CAG_OP_INDIRECT,
      CAG_OP_BASED
   } cag_op_mode_e;

   // Implied-register operation
   typedef enum logic [2:0] {
      CAG_IMP_MULTIPLY,
      CAG_IMP_DIVIDE,
      CAG_IMP_ADJ_ADD,
      CAG_IMP_ADJ_SUB,
      CAG_IMP_ROT_RIGHT,
      CAG_IMP_ROT_LEFT
   } cag_imp_op_e;

endpackage

// File: design/cag_reg_map.sv
// Purpose : Maps register codes to bank-file locations
// Assumes : Bank file holds 8 bytes per bank, 4 banks
// Notes   : Combinational lookup in a single always_comb block
`timescale 1ns/1ps
`default_nettype none
module cag_reg_map
   import cag_pkg::*;
(
   input  wire logic                  bank_select_low_in,
   input  wire logic                  bank_select_high_in,
   input  wire logic [2:0]            byte_register_code_in,
   input  wire logic [1:0]            pair_register_code_in,
   output var  logic [4:0]            byte_index_out,
   output var  logic [4:0]            pair_index_out
);
   import cag_pkg::*;

   // -----------------------------------------------------------------
   // Bank offset and index build
   // -----------------------------------------------------------------
   // Code order X,A,C,B,E,D,L,H maps directly to byte slots 0..7
   always_comb begin
      byte_index_out = {bank_select_high_in, bank_select_low_in,
                        byte_register_code_in}; // [RULE_12] [RULE_13]
      pair_index_out = {bank_select_high_in, bank_select_low_in,
                        pair_register_code_in, 1'b0}; // [RULE_13]
   end
endmodule
`default_nettype wire

// File: sim/cag_core_chk.sv
// Purpose : Port-level checks for cag_core
// Assumes : Bound to cag_core, single clock
// Notes   : Helper flops note whether the previous edge took a step
`timescale 1ns/1ps
`default_nettype none
module cag_core_chk
   import cag_pkg::*;
#(
   parameter int LEN_W = 3
)(
   input wire logic                  clk_in,
   input wire logic                  srst_in,
   input wire logic                  step_in,
   input wire cag_pkg::cag_pc_mode_e pc_mode_in,
   input wire logic                  cond_taken_in,
   input wire logic [LEN_W-1:0]      instr_len_in,
   input wire logic [7:0]            opcode_in,
   input wire logic [7:0]            imm_byte_in,
   input wire logic [15:0]           imm_word_in,
   input wire logic [15:0]           table_entry_in,
   input wire cag_pkg::cag_op_mode_e op_mode_in,
   input wire logic [15:0]           base_pointer_pair_in,
   input wire logic [15:0]           accumulator_pair_in,
   input wire logic [15:0]           sel_pair_in,
   input wire logic [15:0]           pc_out,
   input wire logic [15:0]           table_addr_out,
   input wire logic [15:0]           op_addr_out,
   input wire logic                  op_is_mem_out
);
   import cag_pkg::*;

   logic         tk_r;
   cag_pc_mode_e pm_r;
   cag_op_mode_e om_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // Step taken at the previous edge
   always_ff @(posedge clk_in) begin
      tk_r <= step_in && !srst_in;
      pm_r <= pc_mode_in;
      om_r <= op_mode_in;
   end
   a_pc_seq: assert property (
      tk_r && pm_r == CAG_PC_SEQ |-> pc_out == $past(pc_out) + 16'($past(instr_len_in)))
      else $error("sequential pc wrong");
   a_pc_rel: assert property (
      tk_r && pm_r == CAG_PC_REL && $past(cond_taken_in) |-> pc_out == $past(pc_out)
      + 16'($past(instr_len_in)) + {{8{$past(imm_byte_in[7])}}, $past(imm_byte_in)})
      else $error("relative pc wrong");
   a_pc_abs: assert property (
      tk_r && pm_r == CAG_PC_ABS |-> pc_out == $past(imm_word_in))
      else $error("absolute pc wrong");
   a_pc_fixed: assert property (
      tk_r && pm_r == CAG_PC_FIXED |-> pc_out == {5'h01, $past(imm_word_in[10:0])})
      else $error("fixed call pc wrong");
   a_pc_table: assert property (
      tk_r && pm_r == CAG_PC_TABLE |-> pc_out == $past(table_entry_in))
      else $error("table pc wrong");
   a_pc_hold: assert property (
      !tk_r || pm_r == CAG_PC_HOLD |-> $stable(pc_out))
      else $error("pc moved without cause");
   a_table_addr: assert property (
      !$past(srst_in) |-> table_addr_out == {10'h001, $past(opcode_in[5:1]), 1'b0})
      else $error("table address wrong");
   a_op_short: assert property (
      tk_r && om_r == CAG_OP_SHORT |-> op_is_mem_out
      && op_addr_out == {7'h7F, $past(imm_byte_in) < 8'h20, $past(imm_byte_in)})
      else $error("short address wrong");
   a_op_sfr: assert property (
      tk_r && om_r == CAG_OP_SFR |-> op_is_mem_out && op_addr_out == {8'hFF, $past(imm_byte_in)})
      else $error("sfr address wrong");
   a_op_based: assert property (
      tk_r && om_r == CAG_OP_BASED |-> op_is_mem_out
      && op_addr_out == $past(base_pointer_pair_in) + {8'h00, $past(imm_byte_in)})
      else $error("based address wrong");
   a_pc_acc: assert property (
      tk_r && pm_r == CAG_PC_ACC |-> pc_out == $past(accumulator_pair_in))
      else $error("register branch pc wrong");
   a_op_direct: assert property (
      tk_r && om_r == CAG_OP_DIRECT |-> op_is_mem_out && op_addr_out == $past(imm_word_in))
      else $error("direct address wrong");
   a_op_indirect: assert property (
      tk_r && om_r == CAG_OP_INDIRECT |-> op_is_mem_out && op_addr_out == $past(sel_pair_in))
      else $error("indirect address wrong");
endmodule
`default_nettype wire

// File: sim/cag_core_tb.sv
// Purpose : Self-checking bench for cag_core
// Assumes : Far-side model answers pair and table reads
// Notes   : Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module cag_core_tb;
   import cag_pkg::*;
   localparam int LEN_W = 3;
   logic             clk_in = 1'b0;
   logic             srst_in = 1'b1;
   logic             step_in = 1'b0;
   cag_pc_mode_e     pc_mode_in = CAG_PC_HOLD;
   logic             cond_taken_in = 1'b0;
   logic [LEN_W-1:0] instr_len_in = '0;
   logic [7:0]       opcode_in = 8'h00;
   logic [7:0]       imm_byte_in = 8'h00;
   logic [15:0]      imm_word_in = 16'h0000;
   cag_op_mode_e     op_mode_in = CAG_OP_NONE;
   cag_imp_op_e      imp_op_in = CAG_IMP_MULTIPLY;
   logic [2:0]       byte_register_code_in = 3'h0;
   logic [1:0]       pair_register_code_in = 2'h0;
   logic             bank_select_low_in = 1'b0;
   logic             bank_select_high_in = 1'b0;
   logic [15:0]      table_entry_in, accumulator_pair_in, sel_pair_in, base_pointer_pair_in;
   logic [15:0]      pc_out, table_addr_out, op_addr_out;
   logic             op_is_mem_out, src_is_pair_out, dst_is_pair_out;
   logic [4:0]       src_reg_index_out, dst_reg_index_out;
   logic [15:0]      pc_e;
   int               err_count = 0;
   int               checks = 0;
   int               cyc = 0;
   logic [60:0]      all_out;
   logic [11:0]      reg_o;

   assign all_out = {pc_out, table_addr_out, op_addr_out, op_is_mem_out, src_reg_index_out,
                     dst_reg_index_out, src_is_pair_out, dst_is_pair_out};
   assign reg_o   = {src_reg_index_out, dst_reg_index_out, src_is_pair_out, dst_is_pair_out};

   cag_core #(.LEN_W(LEN_W)) uut (.*);
   cag_far_model far (
      .bank_in               ({bank_select_high_in, bank_select_low_in}),
      .pair_register_code_in (pair_register_code_in),
      .table_addr_in         (table_addr_out),
      .accumulator_pair_out  (accumulator_pair_in),
      .sel_pair_out          (sel_pair_in),
      .base_pointer_pair_out (base_pointer_pair_in),
      .table_entry_out       (table_entry_in)
   );

   always #20 clk_in = ~clk_in;

   task automatic summarize();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Step for one edge, then one idle edge
   task automatic go();
      step_in = 1'b1;
      @(negedge clk_in);
      step_in = 1'b0;
      @(negedge clk_in);
   endtask

   task automatic pcgo(input cag_pc_mode_e m, input logic [2:0] l, input logic [7:0] b,
                       input logic [15:0] w, input logic t);
      pc_mode_in = m;
      instr_len_in = l;
      imm_byte_in = b;
      imm_word_in = w;
      cond_taken_in = t;
      go();
   endtask

   task automatic opgo(input cag_op_mode_e m, input logic [7:0] b, input logic [15:0] w,
                       input logic [15:0] a, input logic v);
      pc_mode_in = CAG_PC_HOLD;
      op_mode_in = m;
      imm_byte_in = b;
      imm_word_in = w;
      go();
      `CHK({op_addr_out, op_is_mem_out, pc_out}, {a, v, pc_e})
   endtask

   task automatic t_pc();
      pc_e = 16'h0000;
      for (int i = 1; i <= 4; i++) begin
         pcgo(CAG_PC_SEQ, 3'(i), 8'h00, 16'h0000, 1'b0);
         pc_e = pc_e + 16'(i);
         `CHK(pc_out, pc_e)
      end
      pcgo(CAG_PC_REL, 3'h2, 8'h80, 16'h0000, 1'b1);
      pc_e = pc_e + 16'h0002 - 16'h0080;
      `CHK(pc_out, pc_e)
      pcgo(CAG_PC_REL, 3'h3, 8'h7F, 16'h0000, 1'b1);
      pc_e = pc_e + 16'h0082;
      `CHK(pc_out, pc_e)
      pcgo(CAG_PC_REL, 3'h2, 8'h80, 16'h0000, 1'b0);
      pc_e = pc_e + 16'h0002;
      `CHK(pc_out, pc_e)
      pcgo(CAG_PC_ABS, 3'h3, 8'h00, 16'hFFFE, 1'b0);
      `CHK(pc_out, 16'hFFFE)
      pcgo(CAG_PC_FIXED, 3'h2, 8'h00, 16'hFFFF, 1'b0);
      `CHK(pc_out, 16'h0FFF)
      pcgo(CAG_PC_FIXED, 3'h2, 8'h00, 16'h0000, 1'b0);
      `CHK(pc_out, 16'h0800)
      opcode_in = 8'hC1;
      @(negedge clk_in);
      `CHK(table_addr_out, 16'h0040)
      opcode_in = 8'h3E;
      @(negedge clk_in);
      `CHK(table_addr_out, 16'h007E)
      pcgo(CAG_PC_TABLE, 3'h1, 8'h00, 16'h0000, 1'b0);
      `CHK(pc_out, 16'h7E5A)
      bank_select_high_in = 1'b1;
      pcgo(CAG_PC_ACC, 3'h1, 8'h00, 16'h0000, 1'b0);
      pc_e = 16'h8FF0;
      `CHK(pc_out, pc_e)
      $display("t_pc done");
   endtask

   task automatic t_ops();
      bank_select_low_in = 1'b1;
      opgo(CAG_OP_DIRECT, 8'h00, 16'hFE00, 16'hFE00, 1'b1);
      opgo(CAG_OP_SHORT, 8'h00, 16'h0000, 16'hFF00, 1'b1);
      opgo(CAG_OP_SHORT, 8'h1F, 16'h0000, 16'hFF1F, 1'b1);
      opgo(CAG_OP_SHORT, 8'h20, 16'h0000, 16'hFE20, 1'b1);
      opgo(CAG_OP_SHORT, 8'hFE, 16'h0000, 16'hFEFE, 1'b1);
      opgo(CAG_OP_SFR, 8'h00, 16'h0000, 16'hFF00, 1'b1);
      opgo(CAG_OP_SFR, 8'hCF, 16'h0000, 16'hFFCF, 1'b1);
      opgo(CAG_OP_SFR, 8'hE0, 16'h0000, 16'hFFE0, 1'b1);
      for (int p = 0; p < 4; p++) begin
         pair_register_code_in = 2'(p);
         opgo(CAG_OP_INDIRECT, 8'h00, 16'h0000, {2'h3, 2'(p), 12'hFF0}, 1'b1);
      end
      opgo(CAG_OP_BASED, 8'h20, 16'h0000, 16'h0010, 1'b1);
      opgo(CAG_OP_NONE, 8'h55, 16'h1234, 16'h0000, 1'b0);
      $display("t_ops done");
   endtask

   task automatic t_regs();
      logic [4:0] ai;
      logic [4:0] pi;
      for (int b = 0; b < 4; b++) begin
         {bank_select_high_in, bank_select_low_in} = 2'(b);
         for (int c = 0; c < 8; c++) begin
            byte_register_code_in = 3'(c);
            pair_register_code_in = 2'(c);
            op_mode_in = CAG_OP_REG_BYTE;
            go();
            `CHK(reg_o, {2'(b), 3'(c), 2'(b), 3'(c), 2'b00})
            op_mode_in = CAG_OP_REG_PAIR;
            go();
            `CHK(reg_o, {2'(b), 2'(c), 1'b0, 2'(b), 2'(c), 1'b0, 2'b11})
         end
      end
      ai = {2'h3, REG_A};
      pi = {2'h3, PAIR_ACC, 1'b0};
      for (int i = 0; i < 6; i++) begin
         imp_op_in = cag_imp_op_e'(i);
         op_mode_in = (i < 2) ? CAG_OP_IMPLIED_PAIR : CAG_OP_IMPLIED_BYTE;
         go();
         `CHK({src_reg_index_out, src_is_pair_out}, (i == 1) ? {pi, 1'b1} : {ai, 1'b0})
         `CHK({dst_reg_index_out, dst_is_pair_out}, (i < 2) ? {pi, 1'b1} : {ai, 1'b0})
         `CHK(src_reg_index_out, (i == 1) ? pi : ai)
         `CHK(dst_reg_index_out, (i < 2) ? pi : ai)
      end
      $display("t_regs done");
   endtask

   // Mid-run reset wins over a pending step and clears every output
   task automatic t_rst();
      srst_in = 1'b1;
      step_in = 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK(all_out, 61'h0)
      srst_in = 1'b0;
      step_in = 1'b0;
      $display("t_rst done");
   endtask

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      repeat (20) @(posedge clk_in);
      @(negedge clk_in);
      `CHK(all_out, 61'h0)
      srst_in = 1'b0;
      t_pc();
      t_ops();
      t_regs();
      t_rst();
      summarize();
   end
endmodule
bind cag_core cag_core_chk #(.LEN_W(LEN_W)) u_chk (.*);
`default_nettype wire

// File: sim/cag_far_model.sv
// Purpose : Bank file and table memory seen by cag_core
// Assumes : Pair value = {bank, pair, FF0H}, table word = {addr low, 5AH}
// Notes   : Combinational answers, as the host fetches them
`timescale 1ns/1ps
`default_nettype none
module cag_far_model (
   input  wire logic [1:0]  bank_in,
   input  wire logic [1:0]  pair_register_code_in,
   input  wire logic [15:0] table_addr_in,
   output var  logic [15:0] accumulator_pair_out,
   output var  logic [15:0] sel_pair_out,
   output var  logic [15:0] base_pointer_pair_out,
   output var  logic [15:0] table_entry_out
);
   assign accumulator_pair_out  = {bank_in, 2'h0, 12'hFF0};
   assign sel_pair_out          = {bank_in, pair_register_code_in, 12'hFF0};
   assign base_pointer_pair_out = {bank_in, 2'h3, 12'hFF0};
   assign table_entry_out       = {table_addr_in[7:0], 8'h5A};
endmodule
`default_nettype wire
